// [verilog/rpah_consts.svh]
// Offsets, reset values and timing counts of the reset pin and auto-halt block
`ifndef RPAH_CONSTS_SVH
`define RPAH_CONSTS_SVH
`define RPAH_CLK_HZ          100000000
`define RPAH_REG_CLR_ADDR    8'h84
`define RPAH_CLR_VALUE       8'h01
`define RPAH_HALT_MS_DEF     1020
`define RPAH_CYC_PER_MS      (`RPAH_CLK_HZ / 1000)
`define RPAH_HALT_EN_DEF     1'b1
`define RPAH_NKX             8
`define RPAH_NKY             11
`endif

// [verilog/rpah_pkg.sv]
// Types shared by the reset pin and auto-halt block
`default_nettype none
package rpah_pkg;
	typedef enum logic [0:0] {
		RPAH_RUN  = 1'b0,
		RPAH_HALT = 1'b1
	} rpah_state_type;
	typedef logic [7:0] rpah_byte_type;
endpackage : rpah_pkg
`default_nettype wire

// [verilog/rpah_top.sv]
// Reset-time pin configuration, power-on interrupt and auto-halt control
// What this block does
// [RL1] X lines: push-pull, pull-up on after reset
// [RL2] Y lines: push-pull, pull-down on after reset
// [RL3] Interrupt pin open drain, no pull, low
// [RL4] Serial clock and data open drain, unpulled
// [RL5] Power-on flag holds interrupt low
// [RL6] Writing 0x01 to 0x84 releases interrupt
// [RL7] Halt after inactivity period, default 1020 ms
// [RL8] Auto halt enabled at reset, host disables
// [RL9] Inactivity period programmable by host
// [RL10] Halt stops oscillator, state retained
// [RL11] Halted: registers still accessible, no wake
// [RL12] Key event wakes and restarts count
`include "rpah_consts.svh"
`default_nettype none
module rpah_top #(
	parameter int HALT_MS_DEFAULT = `RPAH_HALT_MS_DEF,
	parameter int CYC_PER_MS      = `RPAH_CYC_PER_MS
) (
	input  wire logic                     CLK_IN,
	input  wire logic                     NRST_IN,
	input  wire logic                     REG_WR_IN,
	input  wire rpah_pkg::rpah_byte_type  REG_ADDR_IN,
	input  wire rpah_pkg::rpah_byte_type  REG_WDATA_IN,
	input  wire logic                     KEY_EVENT_IN,
	input  wire logic                     HALT_EN_IN,
	input  wire logic [15:0]              HALT_MS_IN,
	input  wire logic                     HALT_MS_LOAD_IN,
	output logic [`RPAH_NKX-1:0]          KEYPAD_X_LINES_PULLUP_OUT,
	output logic [`RPAH_NKX-1:0]          KEYPAD_X_LINES_PUSHPULL_OUT,
	output logic [`RPAH_NKY-1:0]          KEYPAD_Y_LINES_PULLDOWN_OUT,
	output logic [`RPAH_NKY-1:0]          KEYPAD_Y_LINES_PUSHPULL_OUT,
	output logic                          HOST_INTERRUPT_OUT_N_O_OUT,
	output logic                          HOST_INTERRUPT_OUT_N_OE_OUT,
	output logic                          HOST_INTERRUPT_PULL_OUT,
	output logic                          SERIAL_PINS_OPEN_DRAIN_OUT,
	output logic                          SERIAL_PINS_PULL_OUT,
	output logic                          OSC_RUN_OUT,
	output logic                          HALTED_OUT,
	output logic                          POWER_ON_INTERRUPT_FLAG_OUT
);
	import rpah_pkg::*;

	rpah_state_type state_q;
	logic           por_flag_q;
	logic           halt_en_q;
	logic [15:0]    halt_ms_q;
	logic [31:0]    cyc_q;
	logic [15:0]    ms_q;
	logic           tick_ms;
	logic           clr_hit;

	// Pin strap configuration as the reset leaves it; nothing changes it later
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			KEYPAD_X_LINES_PULLUP_OUT   <= '1; // see [RL1]
			KEYPAD_X_LINES_PUSHPULL_OUT <= '1; // see [RL1]
			KEYPAD_Y_LINES_PULLDOWN_OUT <= '1; // see [RL2]
			KEYPAD_Y_LINES_PUSHPULL_OUT <= '1; // see [RL2]
			HOST_INTERRUPT_PULL_OUT     <= 1'b0; // see [RL3]
			SERIAL_PINS_OPEN_DRAIN_OUT  <= 1'b1; // see [RL4]
			SERIAL_PINS_PULL_OUT        <= 1'b0; // see [RL4]
		end
	end

	// Clear strobe decode; write-only register so nothing reads back
	assign clr_hit = REG_WR_IN && (REG_ADDR_IN == `RPAH_REG_CLR_ADDR)
		&& (REG_WDATA_IN == `RPAH_CLR_VALUE); // see [RL6]

	// Power-on flag: set by reset, cleared only by the clear write
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			por_flag_q <= 1'b1; // see [RL5]
		end else if (clr_hit) begin
			por_flag_q <= 1'b0; // see [RL6]
		end
	end

	// Open drain: only ever drives low, released means enable off
	assign HOST_INTERRUPT_OUT_N_O_OUT  = 1'b0; // see [RL3]
	assign HOST_INTERRUPT_OUT_N_OE_OUT = por_flag_q; // see [RL3] see [RL5]
	assign POWER_ON_INTERRUPT_FLAG_OUT = por_flag_q;

	// Host configuration of auto halt; sampled only on strobes
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			halt_en_q <= `RPAH_HALT_EN_DEF; // see [RL8]
			halt_ms_q <= 16'(HALT_MS_DEFAULT); // see [RL7]
		end else if (HALT_MS_LOAD_IN) begin
			halt_en_q <= HALT_EN_IN; // see [RL8]
			halt_ms_q <= HALT_MS_IN; // see [RL9]
		end
	end

	// Millisecond enable from the system clock divider
	assign tick_ms = (cyc_q == 32'(CYC_PER_MS - 1));
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN || KEY_EVENT_IN || state_q == RPAH_HALT) begin
			cyc_q <= 32'h0000_0000; // see [RL12]
		end else if (tick_ms) begin
			cyc_q <= 32'h0000_0000;
		end else begin
			cyc_q <= cyc_q + 32'h0000_0001;
		end
	end

	// Inactivity count in ms; a key event restarts it from zero
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN || KEY_EVENT_IN) begin
			ms_q <= 16'h0000; // see [RL12]
		end else if (tick_ms && state_q == RPAH_RUN && ms_q != 16'hFFFF) begin
			ms_q <= ms_q + 16'h0001; // see [RL7]
		end
	end

	// Halt state; register writes never wake it, only key events do
	always_ff @(posedge CLK_IN) begin
		if (!NRST_IN) begin
			state_q <= RPAH_RUN;
		end else begin
			case (state_q)
				RPAH_RUN: begin
					if (!KEY_EVENT_IN && halt_en_q && ms_q >= halt_ms_q) begin
						state_q <= RPAH_HALT; // see [RL7] see [RL8]
					end
				end
				RPAH_HALT: begin
					if (KEY_EVENT_IN) begin
						state_q <= RPAH_RUN; // see [RL12]
					end
				end
				default: begin
					state_q <= RPAH_RUN;
				end
			endcase
		end
	end

	// Oscillator gate; register state is kept since logic is static
	assign OSC_RUN_OUT = (state_q == RPAH_RUN); // see [RL10] see [RL11]
	assign HALTED_OUT  = (state_q == RPAH_HALT);
endmodule : rpah_top
`default_nettype wire

// [testbench/rpah_top_assertions.sv]
// Port checks for the reset pin and auto-halt block
`default_nettype none
module rpah_top_assertions (
	input wire logic CLK_IN, NRST_IN, REG_WR_IN, KEY_EVENT_IN, HALTED_OUT, OSC_RUN_OUT,
	input wire logic HOST_INTERRUPT_OUT_N_OE_OUT,
	input wire rpah_pkg::rpah_byte_type REG_ADDR_IN, REG_WDATA_IN);
	wire logic o = HOST_INTERRUPT_OUT_N_OE_OUT, h = HALTED_OUT, k = KEY_EVENT_IN;
	// Only the exact byte at the clear address counts
	wire logic c = REG_WR_IN && REG_ADDR_IN == 8'h84 && REG_WDATA_IN == 8'h01;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	property p_por; $rose(NRST_IN) |-> o; endproperty
	a_por: assert property (p_por) else $error("irq free");
	property p_clr; c |=> !o; endproperty
	a_clr: assert property (p_clr) else $error("no clear");
	property p_hold; o && !c |=> o; endproperty
	a_hold: assert property (p_hold) else $error("irq lost");
	property p_osc; h != OSC_RUN_OUT; endproperty
	a_osc: assert property (p_osc) else $error("osc");
	property p_wake; k |=> OSC_RUN_OUT && !h; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	property p_stay; h && !k |=> h; endproperty
	a_stay: assert property (p_stay) else $error("woke");
	property p_idle; $rose(h) |-> !$past(k); endproperty
	a_idle: assert property (p_idle) else $error("busy halt");
	property p_cause; $fell(h) |-> $past(k); endproperty
	a_cause: assert property (p_cause) else $error("odd wake");
	c_clr: cover property (c);
	c_halt: cover property ($rose(h));
	c_wake: cover property ($fell(h));
endmodule : rpah_top_assertions
bind rpah_top rpah_top_assertions rpah_top_assertions_inst (.*);
`default_nettype wire

// [testbench/rpah_host.sv]
// Host model issuing register writes
`default_nettype none
module rpah_host (
	input wire logic clk_in,
	output logic wr_out,
	output rpah_pkg::rpah_byte_type addr_out, data_out);
	timeunit 1ns;
	timeprecision 1ns;
	initial {wr_out, addr_out, data_out} = '0;
	// Released lines invert, so stale values cannot pass
	task automatic wr(input rpah_pkg::rpah_byte_type a, d);
		@(posedge clk_in) #1 {wr_out, addr_out, data_out} = {1'b1, a, d};
		@(posedge clk_in) #1 {wr_out, addr_out, data_out} = {1'b0, ~a, ~d};
	endtask : wr
endmodule : rpah_host
`default_nettype wire

// [testbench/rpah_top_tb_top.sv]
// Self-checking bench for the reset pin and auto-halt block
`default_nettype none
module rpah_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK_IN = 0, NRST_IN = 0, KEY_EVENT_IN = 0, HALT_EN_IN = 1, HALT_MS_LOAD_IN = 0;
	logic [15:0] HALT_MS_IN = 0, w;
	wire logic REG_WR_IN, o, r, h, f;
	wire logic [41:0] p;
	wire rpah_pkg::rpah_byte_type REG_ADDR_IN, REG_WDATA_IN;
	int miscompares = 0, samples_checked = 0;
	always #5 CLK_IN = ~CLK_IN;
	rpah_host rpah_host_inst (.clk_in(CLK_IN), .wr_out(REG_WR_IN), .addr_out(REG_ADDR_IN),
		.data_out(REG_WDATA_IN));
	rpah_top #(.CYC_PER_MS(10)) rpah_top_inst (.*, .KEYPAD_X_LINES_PULLUP_OUT(p[41:34]),
		.KEYPAD_X_LINES_PUSHPULL_OUT(p[33:26]), .KEYPAD_Y_LINES_PULLDOWN_OUT(p[25:15]),
		.KEYPAD_Y_LINES_PUSHPULL_OUT(p[14:4]), .HOST_INTERRUPT_OUT_N_O_OUT(p[3]),
		.HOST_INTERRUPT_PULL_OUT(p[2]), .SERIAL_PINS_OPEN_DRAIN_OUT(p[1]),
		.SERIAL_PINS_PULL_OUT(p[0]), .HOST_INTERRUPT_OUT_N_OE_OUT(o), .OSC_RUN_OUT(r),
		.HALTED_OUT(h), .POWER_ON_INTERRUPT_FLAG_OUT(f));
	task automatic chk(input logic g, e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t mismatch", $time);
		end
	endtask : chk
	task automatic close_out;
		if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK_IN);
		#1;
	endtask : cyc
	function automatic int ms2cyc(input int m);
		return m * 10;
	endfunction : ms2cyc
	// One-edge key pulse restarts the idle count
	task automatic key;
		KEY_EVENT_IN = 1;
		cyc(1);
		KEY_EVENT_IN = 0;
	endtask : key
	// The key pulse zeroes the prescaler, so the window spans 16 cycles around the halt
	task automatic halt_at(input int m);
		key;
		cyc(ms2cyc(m) - 12);
		chk(h, 0);
		cyc(16);
		chk(h, 1);
	endtask : halt_at
	task automatic load(input logic e, input int m);
		{HALT_EN_IN, HALT_MS_IN, HALT_MS_LOAD_IN} = {e, 16'(m), 1'b1};
		cyc(1);
		HALT_MS_LOAD_IN = 0;
	endtask : load
	initial begin
		void'($urandom(32'h8717EE28));
		cyc(8);
		NRST_IN = 1;
		cyc(1);
		chk(p == {{38{1'b1}}, 4'h2}, 1);
		chk(o && f && r, 1);
		// Near misses, then random writes; none may clear
		for (int i = 0; i < 20; i++) begin
			w = i > 1 ? 16'($urandom) : i ? 16'h8301 : 16'h8400;
			if (w == 16'h8401) w = 16'h8402;
			rpah_host_inst.wr(w[15:8], w[7:0]);
			chk(o, 1);
		end
		rpah_host_inst.wr(8'h84, 8'h01);
		chk(o || f, 0);
		halt_at(1020);
		rpah_host_inst.wr(8'h84, 8'h01);
		chk(h && !r, 1);
		key;
		chk(r && !h, 1);
		load(1, 2 + $urandom % 7);
		halt_at(HALT_MS_IN);
		key;
		load(0, 1);
		cyc(ms2cyc(9));
		chk(h, 0);
		// Mid-run reset must raise the power-on flag again
		NRST_IN = 0;
		cyc(2);
		NRST_IN = 1;
		cyc(1);
		chk(o && f && r && !h, 1);
		close_out;
	end
	initial begin
		#1000000 miscompares++;
		close_out;
	end
endmodule : rpah_top_tb_top
`default_nettype wire
